/* File: design/cfg_word_mem.sv */
// Purpose: Small configuration word store with registered read data
// Assumes: One write and one read per cycle, read data one cycle after address
// Notes:   Contents clear on reset so every word returns to its default
`timescale 1ns/1ps
module cfg_word_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             ce,
   input  wire logic             rst,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   // ==========================================================
   // Storage
   logic [WIDTH-1:0] mem_reg [DEPTH];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= '0;
         rdata <= '0;
      end
      else if (ce)
      begin
         if (we)
            mem_reg[waddr] <= wdata;
         rdata <= mem_reg[raddr];
      end
   end

endmodule

/* File: design/switch_monitor_pkg.sv */
// Purpose: Shared constants and types for the switch monitor status readback block
// Assumes: 24-bit register words carried in 32-bit serial frames
// Notes:   Frame layout is write flag, 6-bit address, 24-bit data, odd parity bit
package switch_monitor_pkg;

   // ==========================================================
   // Register map
   localparam logic [5:0]  CRC_OFFSET       = 6'h03;
   localparam logic [5:0]  MISC_OFFSET      = 6'h04;
   localparam logic [5:0]  COMP_OFFSET      = 6'h05;
   localparam logic [5:0]  SOFT_RST_OFFSET  = 6'h18;
   localparam logic [5:0]  CFG_BASE_OFFSET  = 6'h1a;
   localparam int          CFG_DEPTH        = 8;
   localparam int          REG_WIDTH        = 24;
   localparam int          INPUT_COUNT      = 24;

   // ==========================================================
   // Field positions and reset values
   localparam int          CRC_LSB          = 0;
   localparam int          CRC_MSB          = 15;
   localparam logic [15:0] CRC_RESET        = 16'hffff;
   localparam logic [15:0] CRC_SEED         = 16'hffff;
   localparam logic [15:0] CRC_POLY         = 16'h1021;
   localparam int          UV_BIT           = 3;
   localparam int          OV_BIT           = 2;
   localparam int          TW_BIT           = 1;
   localparam int          TSD_BIT          = 0;
   localparam logic [23:0] MISC_RESET       = 24'h000000;
   localparam logic [23:0] COMP_RESET       = 24'h000000;
   localparam int          SOFT_RST_BIT     = 0;

   // ==========================================================
   // Serial frame
   localparam logic [5:0]  FRAME_BITS       = 6'h20;
   localparam logic [5:0]  CNT_SAT          = 6'h3f;
   localparam int          FLAG_SPI_ERR     = 7;
   localparam int          FLAG_PAR_ERR     = 6;
   localparam int          FLAG_RESET       = 5;

   typedef struct packed {
      logic        write;
      logic [5:0]  addr;
      logic [23:0] data;
      logic        parity;
   } frame_s;

   typedef struct packed {
      logic [7:0]  flags;
      logic [23:0] data;
   } reply_s;

   typedef struct packed {
      logic undervolt_level;
      logic overvolt_level;
      logic thermal_warn_level;
      logic thermal_shutdown_level;
   } supply_thermal_s;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_DECODE   = 3'b001,
      ST_REPLY    = 3'b010,
      ST_CRC_RUN  = 3'b011,
      ST_CRC_DONE = 3'b100
   } ctrl_state_e;

endpackage

/* File: design/switch_monitor_status.sv */
// Purpose: Status readback registers behind a 32-bit serial frame port
// Assumes: Serial clock idles while chip select is high; mode 0 framing
// Notes:   Reply to a frame is shifted out during the following frame
// Behaviour
// - CRC field bits 15-0 reset to ffff, bits 23-16 read zero.
// - CRC least significant bit sits in field bit 0, most in 15.
// - CRC readback register lives at offset 3 with reset ffff.
// - Supply/thermal status at offset 4, reset zero, bits 23-4 read zero.
// - Supply/thermal status holds only live read-only condition levels.
// - Bit 3 reads 1 while supply below under-voltage threshold.
// - Bit 2 reads 1 while supply above over-voltage threshold.
// - Bit 1 reads 1 while junction above warning temperature.
// - Bit 0 reads 1 while junction above shutdown temperature.
// - Comparator status bit n reads 1 when input n is above threshold.
// - Comparator status at offset 5, read-only, reset zero.
// - Hardware or software reset returns every register and state to default; software reset leaves the serial-side registers and synchronisers untouched.
// - Only exactly 32-bit frames are accepted; other nonzero lengths flag an error.
`timescale 1ns/1ps
module switch_monitor_status #(
   parameter int CFG_DEPTH   = switch_monitor_pkg::CFG_DEPTH,
   parameter int INPUT_COUNT = switch_monitor_pkg::INPUT_COUNT
) (
   input  wire logic                                clk,
   input  wire logic                                ce,
   input  wire logic                                srst,
   input  wire logic                                sclk,
   input  wire logic                                cs_n,
   input  wire logic                                sdi,
   output logic                                     sdo,
   output logic                                     sdo_en_n,
   input  wire switch_monitor_pkg::supply_thermal_s supply_thermal,
   input  wire logic [INPUT_COUNT-1:0]              threshold_above
);

   localparam int AW = $clog2(CFG_DEPTH);

   // ==========================================================
   // Declarations
   switch_monitor_pkg::ctrl_state_e state_reg;
   switch_monitor_pkg::ctrl_state_e state_next;
   switch_monitor_pkg::frame_s      rx_cap_reg;
   switch_monitor_pkg::reply_s      tx_word_reg;
   switch_monitor_pkg::supply_thermal_s st_s1_reg;
   switch_monitor_pkg::supply_thermal_s st_s2_reg;
   logic [5:0]              bit_cnt_reg;
   logic [5:0]              bit_cnt_next;
   logic [31:0]             shift_reg;
   logic                    in_frame_reg;
   logic                    neg_seen_reg;
   logic                    sdo_reg;
   logic                    start_tog_reg;
   logic                    link_rst_reg;
   logic                    frame_clr;
   logic                    cs_s1_reg;
   logic                    cs_s2_reg;
   logic                    cs_s3_reg;
   logic                    cs_s4_reg;
   logic                    tog_s1_reg;
   logic                    tog_s2_reg;
   logic                    seen_reg;
   logic                    cs_rise;
   logic                    got_clocks;
   logic [5:0]              len_cap_reg;
   logic                    pend_reg;
   logic                    crc_pend_reg;
   logic                    soft_rst_reg;
   logic                    int_rst;
   logic [15:0]             crc_reg;
   logic [15:0]             crc_acc_reg;
   logic [15:0]             crc_acc_next;
   logic [AW-1:0]           crc_idx_reg;
   logic                    issue_reg;
   logic [23:0]             misc_reg;
   logic [INPUT_COUNT-1:0]  comp_s1_reg;
   logic [INPUT_COUNT-1:0]  comp_s2_reg;
   logic [INPUT_COUNT-1:0]  comp_reg;
   logic                    spi_err_reg;
   logic                    par_err_reg;
   logic                    reset_flag_reg;
   logic                    len_ok;
   logic                    par_ok;
   logic                    frame_ok;
   logic                    cfg_hit;
   logic [5:0]              cfg_off;
   logic [AW-1:0]           cfg_idx;
   logic                    mem_we;
   logic [AW-1:0]           mem_raddr;
   logic [23:0]             mem_rdata;
   logic [23:0]             read_mux;
   logic [4:0]              tx_idx;
   logic                    soft_rst_req;

   // ==========================================================
   // Link side, serial clock domain
   assign frame_clr    = cs_n | link_rst_reg;
   assign bit_cnt_next = !in_frame_reg ? 6'h01 :
                         (bit_cnt_reg == switch_monitor_pkg::CNT_SAT) ? bit_cnt_reg : bit_cnt_reg + 6'h01;

   always_ff @(posedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
         in_frame_reg <= 1'b0;
      else
         in_frame_reg <= 1'b1;
   end

   // Count and frame word survive chip select so the clock side can read them afterwards
   always_ff @(posedge sclk or posedge link_rst_reg)
   begin
      if (link_rst_reg)
      begin
         bit_cnt_reg   <= 6'h00;
         shift_reg     <= 32'h00000000;
         start_tog_reg <= 1'b0;
      end
      else
      begin
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= {shift_reg[30:0], sdi};
         if (!in_frame_reg)
            start_tog_reg <= ~start_tog_reg;
      end
   end

   assign tx_idx = 5'h1f - bit_cnt_reg[4:0];

   always_ff @(negedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         neg_seen_reg <= 1'b0;
         sdo_reg      <= 1'b0;
      end
      else
      begin
         neg_seen_reg <= 1'b1;
         sdo_reg      <= bit_cnt_reg[5] ? 1'b0 : tx_word_reg[tx_idx];
      end
   end

   // First bit must be on the wire before any clock edge arrives
   assign sdo      = neg_seen_reg ? sdo_reg : tx_word_reg[31];
   assign sdo_en_n = cs_n;

   // ==========================================================
   // Crossings into the system clock domain
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cs_s1_reg    <= 1'b1;
         cs_s2_reg    <= 1'b1;
         cs_s3_reg    <= 1'b1;
         cs_s4_reg    <= 1'b1;
         tog_s1_reg   <= 1'b0;
         tog_s2_reg   <= 1'b0;
         st_s1_reg    <= '0;
         st_s2_reg    <= '0;
         comp_s1_reg  <= '0;
         comp_s2_reg  <= '0;
         link_rst_reg <= 1'b1;
      end
      else if (ce)
      begin
         cs_s1_reg    <= cs_n;
         cs_s2_reg    <= cs_s1_reg;
         cs_s3_reg    <= cs_s2_reg;
         cs_s4_reg    <= cs_s3_reg;
         tog_s1_reg   <= start_tog_reg;
         tog_s2_reg   <= tog_s1_reg;
         st_s1_reg    <= supply_thermal;
         st_s2_reg    <= st_s1_reg;
         comp_s1_reg  <= threshold_above;
         comp_s2_reg  <= comp_s1_reg;
         link_rst_reg <= 1'b0;
      end
   end

   // Extra delay stage lets the start toggle settle before the frame is judged
   assign cs_rise    = cs_s3_reg & ~cs_s4_reg;
   // A frame with no clock edges at all is silently ignored
   assign got_clocks = tog_s2_reg != seen_reg;

   // ==========================================================
   // Frame decode
   assign len_ok    = len_cap_reg == switch_monitor_pkg::FRAME_BITS;
   assign par_ok    = ^rx_cap_reg;
   assign frame_ok  = len_ok & par_ok;
   assign cfg_off   = rx_cap_reg.addr - switch_monitor_pkg::CFG_BASE_OFFSET;
   assign cfg_hit   = (rx_cap_reg.addr >= switch_monitor_pkg::CFG_BASE_OFFSET)
                      && (cfg_off < 6'(CFG_DEPTH));
   assign cfg_idx   = cfg_off[AW-1:0];
   assign mem_we    = (state_reg == switch_monitor_pkg::ST_DECODE) && frame_ok && rx_cap_reg.write && cfg_hit;
   assign mem_raddr = (state_reg == switch_monitor_pkg::ST_CRC_RUN) ? crc_idx_reg : cfg_idx;
   assign soft_rst_req = (state_reg == switch_monitor_pkg::ST_DECODE) && frame_ok && rx_cap_reg.write
                         && (rx_cap_reg.addr == switch_monitor_pkg::SOFT_RST_OFFSET)
                         && rx_cap_reg.data[switch_monitor_pkg::SOFT_RST_BIT];
   assign int_rst   = srst | soft_rst_reg;

   // Read-only registers ignore writes; unmapped offsets read zero
   assign read_mux =
      (rx_cap_reg.addr == switch_monitor_pkg::CRC_OFFSET)  ? {8'h00, crc_reg} :
      (rx_cap_reg.addr == switch_monitor_pkg::MISC_OFFSET) ? misc_reg :
      (rx_cap_reg.addr == switch_monitor_pkg::COMP_OFFSET) ? comp_reg :
      cfg_hit ? mem_rdata : 24'h000000;

   // ==========================================================
   // Configuration store
   cfg_word_mem #(
      .WIDTH (switch_monitor_pkg::REG_WIDTH),
      .DEPTH (CFG_DEPTH),
      .AW    (AW)
   ) u_cfg (
      .clk   (clk),
      .ce    (ce),
      .rst   (int_rst),
      .we    (mem_we),
      .waddr (cfg_idx),
      .wdata (rx_cap_reg.data),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // ==========================================================
   // CRC over configuration words, most significant data bit first
   function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [23:0] w);
      logic [15:0] c;
      logic        fb;
      c  = c_in;
      fb = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         fb = c[15] ^ w[i];
         c  = {c[14:0], 1'b0} ^ (fb ? switch_monitor_pkg::CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   assign crc_acc_next = issue_reg ? crc_word(crc_acc_reg, mem_rdata) : crc_acc_reg;

   // ==========================================================
   // Control state machine
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         switch_monitor_pkg::ST_IDLE:
            if (pend_reg)
               state_next = switch_monitor_pkg::ST_DECODE;
            else if (crc_pend_reg)
               state_next = switch_monitor_pkg::ST_CRC_RUN;
         switch_monitor_pkg::ST_DECODE:
            state_next = switch_monitor_pkg::ST_REPLY;
         switch_monitor_pkg::ST_REPLY:
            state_next = switch_monitor_pkg::ST_IDLE;
         switch_monitor_pkg::ST_CRC_RUN:
            if (crc_idx_reg == AW'(CFG_DEPTH - 1))
               state_next = switch_monitor_pkg::ST_CRC_DONE;
         switch_monitor_pkg::ST_CRC_DONE:
            state_next = switch_monitor_pkg::ST_IDLE;
         default:
            state_next = switch_monitor_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         soft_rst_reg <= 1'b0;
      else if (ce)
         soft_rst_reg <= soft_rst_req;
   end

   always_ff @(posedge clk)
   begin
      if (int_rst)
      begin
         state_reg      <= switch_monitor_pkg::ST_IDLE;
         seen_reg       <= tog_s2_reg;
         pend_reg       <= 1'b0;
         rx_cap_reg     <= '0;
         len_cap_reg    <= 6'h00;
         tx_word_reg    <= '0;
         spi_err_reg    <= 1'b0;
         par_err_reg    <= 1'b0;
         reset_flag_reg <= 1'b1;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         // Frame word is grabbed at once; a busy CRC walk only delays the decode
         if (cs_rise && got_clocks)
         begin
            seen_reg    <= tog_s2_reg;
            rx_cap_reg  <= shift_reg;
            len_cap_reg <= bit_cnt_reg;
            pend_reg    <= 1'b1;
         end
         else if (state_reg == switch_monitor_pkg::ST_IDLE)
            pend_reg <= 1'b0;
         if (state_reg == switch_monitor_pkg::ST_DECODE)
         begin
            spi_err_reg <= !len_ok;
            par_err_reg <= len_ok && !par_ok;
         end
         if (state_reg == switch_monitor_pkg::ST_REPLY)
         begin
            tx_word_reg.flags <= {spi_err_reg, par_err_reg, reset_flag_reg, 5'h00};
            tx_word_reg.data  <= read_mux;
            if (!spi_err_reg && !par_err_reg)
               reset_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (int_rst)
      begin
         crc_reg      <= switch_monitor_pkg::CRC_RESET;
         crc_acc_reg  <= switch_monitor_pkg::CRC_SEED;
         crc_idx_reg  <= '0;
         crc_pend_reg <= 1'b0;
         issue_reg    <= 1'b0;
      end
      else if (ce)
      begin
         issue_reg   <= state_reg == switch_monitor_pkg::ST_CRC_RUN;
         crc_acc_reg <= crc_acc_next;
         // A write landing during a walk re-arms it, set wins over clear
         if (mem_we)
            crc_pend_reg <= 1'b1;
         else if (state_reg == switch_monitor_pkg::ST_IDLE && !pend_reg && crc_pend_reg)
         begin
            crc_pend_reg <= 1'b0;
            crc_acc_reg  <= switch_monitor_pkg::CRC_SEED;
            crc_idx_reg  <= '0;
         end
         if (state_reg == switch_monitor_pkg::ST_CRC_RUN)
            crc_idx_reg <= crc_idx_reg + AW'(1);
         if (state_reg == switch_monitor_pkg::ST_CRC_DONE)
            crc_reg <= crc_acc_next;
      end
   end

   // ==========================================================
   // Live status readback
   always_ff @(posedge clk)
   begin
      if (int_rst)
      begin
         misc_reg <= switch_monitor_pkg::MISC_RESET;
         comp_reg <= switch_monitor_pkg::COMP_RESET;
      end
      else if (ce)
      begin
         misc_reg                              <= 24'h000000;
         misc_reg[switch_monitor_pkg::UV_BIT]  <= st_s2_reg.undervolt_level;
         misc_reg[switch_monitor_pkg::OV_BIT]  <= st_s2_reg.overvolt_level;
         misc_reg[switch_monitor_pkg::TW_BIT]  <= st_s2_reg.thermal_warn_level;
         misc_reg[switch_monitor_pkg::TSD_BIT] <= st_s2_reg.thermal_shutdown_level;
         comp_reg                              <= comp_s2_reg;
      end
   end

endmodule

/* File: dv/host_spi_model.sv */
// Purpose: Host controller model that drives serial frames into the block
// Assumes: Mode 0, serial clock idles low and stands still outside frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module host_spi_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo_line
);
   // ======================================
   // Frame engine
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // Any length up to 33 bits is accepted so the bench can break framing on purpose
   task automatic xfer(input logic [32:0] bits, input int n, output logic [31:0] rx);
      rx   = 32'h0;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = bits[i];
         #7.5 sclk = 1'b1;
         rx = {rx[30:0], sdo_line};
         #7.5 sclk = 1'b0;
      end
      #110 cs_n = 1'b1;
      sdi = ~sdi;
   endtask
endmodule

/* File: dv/switch_monitor_status_props.sv */
// Purpose: Port-level checks of the status readback block
// Assumes: No frame without serial clock edges; srst only between frames
// Notes:   Replies are judged one frame late, as the block answers
`timescale 1ns/1ps
module switch_monitor_status_props #(
   parameter int CFG_DEPTH   = 8,
   parameter int INPUT_COUNT = 24
) (
   input wire logic                   clk,
   input wire logic                   srst,
   input wire logic                   sclk,
   input wire logic                   cs_n,
   input wire logic                   sdi,
   input wire logic                   sdo,
   input wire logic                   sdo_en_n,
   input wire logic [3:0]             supply_thermal,
   input wire logic [INPUT_COUNT-1:0] threshold_above
);
   // ======================================
   // Frame capture
   logic [5:0]  bit_cnt;
   logic [5:0]  last_len;
   logic [31:0] in_sh;
   logic [31:0] out_sh;
   logic [31:0] last_in;
   logic        wrote_cfg;
   wire         cur_full  = (bit_cnt == 6'h20);
   wire         cur_ok    = cur_full && (^in_sh) && in_sh[31];
   wire         cfg_write = cur_ok && (in_sh[30:25] >= switch_monitor_pkg::CFG_BASE_OFFSET)
                            && (int'(in_sh[30:25]) < int'(switch_monitor_pkg::CFG_BASE_OFFSET) + CFG_DEPTH);
   wire         soft_rst  = cur_ok && (in_sh[30:25] == switch_monitor_pkg::SOFT_RST_OFFSET) && in_sh[1];
   wire         prev_ok   = (last_len == 6'h20) && (^last_in) && !last_in[31];
   wire  [5:0]  prev_addr = last_in[30:25];

   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         bit_cnt <= 6'h00;
         in_sh   <= 32'h0;
         out_sh  <= 32'h0;
      end
      else
      begin
         bit_cnt <= (bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h01;
         in_sh   <= {in_sh[30:0], sdi};
         out_sh  <= {out_sh[30:0], sdo};
      end
   end

   // Length zero marks the previous reply as unknown after a reset
   always_ff @(posedge cs_n or posedge srst)
   begin
      if (srst)
      begin
         last_len  <= 6'h00;
         last_in   <= 32'h0;
         wrote_cfg <= 1'b0;
      end
      else
      begin
         last_len  <= bit_cnt;
         last_in   <= in_sh;
         wrote_cfg <= cfg_write ? 1'b1 : (soft_rst ? 1'b0 : wrote_cfg);
      end
   end

   // ======================================
   // Assertions
   property p_en_tracks_cs;
      @(posedge clk) disable iff (srst) sdo_en_n == cs_n;
   endproperty
   a_en_tracks_cs: assert property (p_en_tracks_cs) else $error("enable not chip select");
   property p_len_error;
      @(posedge cs_n) disable iff (srst) cur_full && last_len != 6'h20 && last_len != 6'h00 |-> out_sh[31];
   endproperty
   a_len_error: assert property (p_len_error) else $error("length error missing");
   property p_parity_error;
      @(posedge cs_n) disable iff (srst) cur_full && last_len == 6'h20 && !(^last_in) |-> out_sh[30];
   endproperty
   a_parity_error: assert property (p_parity_error) else $error("parity error missing");
   property p_crc_reserved;
      @(posedge cs_n) disable iff (srst) cur_full && prev_ok && prev_addr == 6'h03 |-> out_sh[23:16] == 8'h00;
   endproperty
   a_crc_reserved: assert property (p_crc_reserved) else $error("crc reserved set");
   property p_crc_default;
      @(posedge cs_n) disable iff (srst) cur_full && prev_ok && prev_addr == 6'h03 && !wrote_cfg
         |-> out_sh[15:0] == 16'hffff;
   endproperty
   a_crc_default: assert property (p_crc_default) else $error("crc not default");
   property p_misc_reserved;
      @(posedge cs_n) disable iff (srst) cur_full && prev_ok && prev_addr == 6'h04 |-> out_sh[23:4] == 20'h0;
   endproperty
   a_misc_reserved: assert property (p_misc_reserved) else $error("status reserved set");
   property p_misc_levels;
      @(posedge cs_n) disable iff (srst) cur_full && prev_ok && prev_addr == 6'h04 |-> out_sh[3:0] == supply_thermal;
   endproperty
   a_misc_levels: assert property (p_misc_levels) else $error("supply levels wrong");
   property p_comp_levels;
      @(posedge cs_n) disable iff (srst) cur_full && prev_ok && prev_addr == 6'h05
         |-> out_sh[23:0] == 24'(threshold_above);
   endproperty
   a_comp_levels: assert property (p_comp_levels) else $error("input levels wrong");
endmodule

bind switch_monitor_status switch_monitor_status_props #(
   .CFG_DEPTH(CFG_DEPTH),
   .INPUT_COUNT(INPUT_COUNT)
) i_switch_monitor_status_props (
   .clk(clk),
   .srst(srst),
   .sclk(sclk),
   .cs_n(cs_n),
   .sdi(sdi),
   .sdo(sdo),
   .sdo_en_n(sdo_en_n),
   .supply_thermal(supply_thermal),
   .threshold_above(threshold_above)
);

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the status readback block
// Assumes: Reply to a frame arrives in the frame after it
// Notes:   Checksum expectations come from a local shadow of the config words
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        ce;
   logic        srst;
   logic        sclk;
   logic        cs_n;
   logic        sdi;
   logic        sdo;
   logic        sdo_en_n;
   logic        sdo_line;
   logic [3:0]  supply_thermal;
   logic [23:0] threshold_above;
   logic [31:0] pre;
   logic [31:0] rsp;
   logic [23:0] cfg [8];
   int          miscompares;
   int          n_compared;

   // Released line shows the inverse
   assign sdo_line = sdo_en_n ? ~sdo : sdo;
   always #50 clk = ~clk;

   switch_monitor_status i_switch_monitor_status (
      .clk(clk), .ce(ce), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .sdo_en_n(sdo_en_n), .supply_thermal(supply_thermal), .threshold_above(threshold_above));
   host_spi_model i_host_spi_model (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

   // ======================================
   // Helpers
   task automatic finish_test();
      $display("miscompares=%0d n_compared=%0d", miscompares, n_compared);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check_data(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // Gap of 20 cycles covers judging, reply build and a full checksum walk
   task automatic send(input logic w, input logic [5:0] a, input logic [23:0] d, input int n, input logic bad);
      logic [31:0] f;
      f = {w, a, d, (~^{w, a, d}) ^ bad};
      @(posedge clk);
      #1;
      i_host_spi_model.xfer((n == 33) ? {f, 1'b0} : ({1'b0, f} >> (32 - n)), n, pre);
      repeat (20) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [5:0] a);
      logic [31:0] hold;
      send(1'b0, a, 24'h0, 32, 1'b0);
      hold = pre;
      send(1'b0, 6'h00, 24'h0, 32, 1'b0);
      rsp = pre;
      pre = hold;
   endtask

   function automatic logic [15:0] crc_of();
      logic [15:0] c;
      logic        fb;
      c = 16'hffff;
      for (int k = 0; k < 8; k++)
         for (int i = 23; i >= 0; i--)
         begin
            fb = c[15] ^ cfg[k][i];
            c = {c[14:0], 1'b0} ^ (fb ? switch_monitor_pkg::CRC_POLY : 16'h0000);
         end
      return c;
   endfunction

   // ======================================
   // Scenarios
   task automatic t_reset_values();
      rd(6'h03);
      check_data(rsp[23:0], 24'h00ffff);
      check_flag(rsp[31], 1'b0);
      rd(6'h04);
      check_data(rsp[23:0], 24'h000000);
      rd(6'h05);
      check_data(rsp[23:0], 24'h000000);
   endtask

   task automatic t_misc_levels();
      for (int i = 0; i < 4; i++)
      begin
         supply_thermal = 4'b0001 << i;
         repeat (5) @(posedge clk);
         rd(6'h04);
         check_data(rsp[23:0], {20'h0, 4'b0001 << i});
      end
      send(1'b1, 6'h04, 24'hffffff, 32, 1'b0);
      rd(6'h04);
      check_data(rsp[23:0], 24'h000008);
      supply_thermal = 4'h0;
   endtask

   task automatic t_comp_levels();
      logic [23:0] pat [4];
      pat = '{24'h800001, 24'ha5c30f, 24'h5a3cf0, 24'hffffff};
      foreach (pat[i])
      begin
         threshold_above = pat[i];
         repeat (5) @(posedge clk);
         rd(6'h05);
         check_data(rsp[23:0], pat[i]);
      end
      send(1'b1, 6'h05, 24'h000000, 32, 1'b0);
      rd(6'h05);
      check_data(rsp[23:0], 24'hffffff);
   endtask

   task automatic t_crc_write();
      cfg[0] = 24'h123456;
      send(1'b1, 6'h1a, cfg[0], 32, 1'b0);
      rd(6'h03);
      check_data(rsp[23:0], {8'h00, crc_of()});
      cfg[7] = 24'habcdef;
      send(1'b1, 6'h21, cfg[7], 32, 1'b0);
      send(1'b1, 6'h03, 24'h000000, 32, 1'b0);
      rd(6'h03);
      check_data(rsp[23:0], {8'h00, crc_of()});
      rd(6'h1a);
      check_data(rsp[23:0], cfg[0]);
   endtask

   task automatic t_frame_errors();
      send(1'b1, 6'h1a, 24'h777777, 31, 1'b0);
      rd(6'h03);
      check_flag(pre[31], 1'b1);
      check_data(rsp[23:0], {8'h00, crc_of()});
      send(1'b1, 6'h1a, 24'h777777, 33, 1'b0);
      rd(6'h03);
      check_flag(pre[31], 1'b1);
      check_flag(rsp[31], 1'b0);
      send(1'b1, 6'h1a, 24'h777777, 32, 1'b1);
      rd(6'h03);
      check_flag(pre[30], 1'b1);
      check_data(rsp[23:0], {8'h00, crc_of()});
   endtask

   task automatic t_resets();
      send(1'b1, 6'h18, 24'h000001, 32, 1'b0);
      cfg = '{default: 24'h0};
      rd(6'h03);
      check_data(rsp[23:0], 24'h00ffff);
      rd(6'h1a);
      check_data(rsp[23:0], 24'h000000);
      send(1'b1, 6'h1b, 24'h0f0f0f, 32, 1'b0);
      srst = 1'b1;
      repeat (3) @(posedge clk);
      #1 srst = 1'b0;
      repeat (3) @(posedge clk);
      rd(6'h03);
      check_data(rsp[23:0], 24'h00ffff);
   endtask

   // ======================================
   // Main sequence and watchdog
   initial
   begin
      clk = 1'b0;
      ce = 1'b1;
      srst = 1'b1;
      supply_thermal = 4'h0;
      threshold_above = 24'h0;
      miscompares = 0;
      n_compared = 0;
      cfg = '{default: 24'h0};
      repeat (12) @(posedge clk);
      #1 srst = 1'b0;
      repeat (3) @(posedge clk);
      t_reset_values();
      t_misc_levels();
      t_comp_levels();
      t_crc_write();
      t_frame_errors();
      t_resets();
      finish_test();
   end

   initial
   begin
      #1_000_000;
      miscompares++;
      finish_test();
   end
endmodule
